// [hdl/sgc_pkg.sv]
// Package with register map, field positions, reset values and timing for global control
package sgc_pkg;
  localparam logic [6:0] ADDR_GLOBAL_CONTROL_ZERO = 7'h02;
  localparam logic [6:0] ADDR_GLOBAL_CONTROL_ONE  = 7'h03;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // Global control zero fields
  localparam int GC0_RSVD_BIT      = 7;
  localparam int GC0_PRIO_HI       = 6;
  localparam int GC0_PRIO_LO       = 4;
  localparam int GC0_MII_EN_BIT    = 3;
  localparam int GC0_SHARE_BIT     = 2;
  localparam int GC0_CONF_DROP_BIT = 1;
  localparam int GC0_LINK_AGE_BIT  = 0;
  // Global control one fields
  localparam int GC1_PASS_ALL_BIT  = 7;
  localparam int GC1_RSVD_BIT      = 6;
  localparam int GC1_TX_FC_DIS_BIT = 5;
  localparam int GC1_RX_FC_DIS_BIT = 4;
  localparam int GC1_LEN_CHK_BIT   = 3;
  localparam int GC1_LOW_HI        = 2;
  // Reset values of fixed fields
  localparam logic [2:0] BASE_PRIO_RST = 3'h4;
  localparam logic       SHARE_RST     = 1'h1;
  // Frame matching constants
  localparam logic [15:0] PAUSE_ETHERTYPE = 16'h8808;
  localparam logic [47:0] PAUSE_DA        = 48'h0180c2000001;
  localparam logic [15:0] MAX_LEN_FIELD   = 16'h05dc;
  // Fast aging bound and normal period
  localparam int CLK_HZ         = 25_000_000;
  localparam int FAST_AGE_US    = 800;
  // Tick lands one cycle inside the bound, so fast aging stays strictly below it
  localparam int FAST_AGE_CYC   = FAST_AGE_US * (CLK_HZ / 1_000_000) - 2;
  localparam int NORMAL_AGE_S   = 300;
  localparam int NORMAL_AGE_EXT = 75;
  localparam longint NORMAL_AGE_CYC = longint'(NORMAL_AGE_S + NORMAL_AGE_EXT) * CLK_HZ;
  localparam int NUM_PORTS = 5;
  // Flops in the strap synchroniser
  localparam int STRAP_SYNC_STAGES = 2;
endpackage : sgc_pkg

// [hdl/sgc_sync2.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sgc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      q    <= s1_q;
    end
  end
endmodule : sgc_sync2
`default_nettype wire

// [hdl/sgc_global_ctrl.sv]
// Global control registers zero and one with the logic they steer
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Tag priority at or above base is high
// - Cleared MII enable tri-states PHY MII outputs
// - MII enable resets from strap, pulled high
// - Sharing off limits port to fifth
// - Conformance mode drops 8808 or pause DA
// - Link loss triggers one fast age cycle
// - Unplugged port ages out all addresses
// - Pass all frames forwards bad ones
// - Tx disable bit overrides negotiated tx pause
// - Rx disable bit overrides negotiated rx pause
// - One strap sets both flow bits
// - Length check drops mismatched short frames
// - All registers reached over serial port
module sgc_global_ctrl
  import sgc_pkg::*;
#(
  parameter int  NPORT       = sgc_pkg::NUM_PORTS,
  parameter longint AGE_CYC  = sgc_pkg::NORMAL_AGE_CYC,
  parameter int  FAST_CYC    = sgc_pkg::FAST_AGE_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Register port from the serial management slave
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [sgc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [sgc_pkg::DATA_W-1:0] reg_wdata,
  output logic      [sgc_pkg::DATA_W-1:0] reg_rdata,
  // Strap pins
  input  wire logic                      phy_mii_enable_strap_pin,
  input  wire logic                      flow_control_strap_pin,
  // Priority classification
  input  wire logic [2:0]                rx_user_priority,
  output logic                           rx_high_priority,
  // PHY-side MII output isolation
  input  wire logic [5:0]                phy_mii_out,
  output logic      [5:0]                phy_mii_o,
  output logic      [5:0]                phy_mii_oe,
  // Buffer sharing
  output logic                           buf_share_all,
  output logic                           buf_per_port_fifth,
  // Frame filter inputs
  input  wire logic                      rx_frame_valid,
  input  wire logic [15:0]               rx_len_type,
  input  wire logic [47:0]               rx_dest_addr,
  input  wire logic                      rx_is_flow_ctrl,
  input  wire logic                      rx_frame_error,
  input  wire logic [15:0]               rx_actual_len,
  output logic                           rx_drop,
  // Flow control
  input  wire logic [NPORT-1:0]          auto_negotiation_tx_pause,
  input  wire logic [NPORT-1:0]          auto_negotiation_rx_pause,
  output logic      [NPORT-1:0]          tx_pause_en,
  output logic      [NPORT-1:0]          rx_pause_en,
  // Aging
  input  wire logic [NPORT-1:0]          port_link_up,
  output logic                           age_tick,
  output logic                           fast_age_active,
  output logic                           flush_all_addr
);
  import sgc_pkg::*;

  logic [DATA_W-1:0] gc0_q;
  logic [DATA_W-1:0] gc1_q;
  logic              strap_mii_s;
  logic              strap_fc_s;
  logic [1:0]        strap_cnt_q;
  logic              strap_load;
  logic [NPORT-1:0]  link_q;
  logic              link_drop;
  logic              fast_q;
  logic [63:0]       age_cnt_q;
  logic              flush_q;
  logic [DATA_W-1:0] rdata_q;

  // Strap pins pass two flops
  sgc_sync2 #(.W(2)) u_strap_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({phy_mii_enable_strap_pin, flow_control_strap_pin}),
    .q      ({strap_mii_s, strap_fc_s})
  );

  // Counts edges after release until one past the edge where the synchroniser holds the straps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q <= '0;
    end else if (strap_cnt_q != 2'(STRAP_SYNC_STAGES + 1)) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end
  // One load edge once both stages are filled; a write to a register on that edge wins and that register's strap bits are not loaded
  assign strap_load = (strap_cnt_q == 2'(STRAP_SYNC_STAGES));

  // Global control zero; mii enable from strap on the load edge after release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gc0_q <= '0;
      gc0_q[GC0_PRIO_HI:GC0_PRIO_LO] <= BASE_PRIO_RST;
      gc0_q[GC0_SHARE_BIT]           <= SHARE_RST;
      gc0_q[GC0_MII_EN_BIT]          <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_GLOBAL_CONTROL_ZERO) begin
      gc0_q <= reg_wdata;
    end else if (strap_load) begin
      gc0_q[GC0_MII_EN_BIT] <= strap_mii_s;
    end
  end

  // Global control one; both flow bits from one strap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gc1_q <= '0;
    end else if (reg_wr && reg_addr == ADDR_GLOBAL_CONTROL_ONE) begin
      gc1_q <= reg_wdata;
    end else if (strap_load) begin
      gc1_q[GC1_TX_FC_DIS_BIT] <= strap_fc_s;
      gc1_q[GC1_RX_FC_DIS_BIT] <= strap_fc_s;
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_GLOBAL_CONTROL_ZERO: rdata_q <= gc0_q;
        ADDR_GLOBAL_CONTROL_ONE:  rdata_q <= gc1_q;
        default:                  rdata_q <= '0;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // Priority compare against base field
  assign rx_high_priority = rx_user_priority >= gc0_q[GC0_PRIO_HI:GC0_PRIO_LO];

  // MII isolation: drivers off while enable is low
  assign phy_mii_o  = phy_mii_out;
  assign phy_mii_oe = {6{gc0_q[GC0_MII_EN_BIT]}};

  // Buffer pool policy
  assign buf_share_all      = gc0_q[GC0_SHARE_BIT];
  assign buf_per_port_fifth = !gc0_q[GC0_SHARE_BIT];

  // Drop decision for a received frame
  always_comb begin
    rx_drop = 1'b0;
    if (rx_frame_valid) begin
      if (gc0_q[GC0_CONF_DROP_BIT]) begin
        if (rx_len_type == PAUSE_ETHERTYPE || rx_dest_addr == PAUSE_DA) begin
          rx_drop = 1'b1;
        end
      end else if (rx_is_flow_ctrl) begin
        rx_drop = 1'b1;
      end
      if (rx_frame_error && !gc1_q[GC1_PASS_ALL_BIT]) begin
        rx_drop = 1'b1;
      end
      if (gc1_q[GC1_LEN_CHK_BIT] && rx_len_type < MAX_LEN_FIELD
          && rx_len_type != rx_actual_len) begin
        rx_drop = 1'b1;
      end
    end
  end

  // Per-port pause enables gated by disable bits
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_fc
      assign tx_pause_en[gi] = auto_negotiation_tx_pause[gi]
                               && !gc1_q[GC1_TX_FC_DIS_BIT];
      assign rx_pause_en[gi] = auto_negotiation_rx_pause[gi]
                               && !gc1_q[GC1_RX_FC_DIS_BIT];
    end
  endgenerate

  // Link history for drop detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_q <= '0;
    end else begin
      link_q <= port_link_up;
    end
  end
  assign link_drop = |(link_q & ~port_link_up);

  // Full address flush on any unplug
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= link_drop;
    end
  end
  assign flush_all_addr = flush_q;

  // Age timer: one fast cycle after link loss, then normal
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_q    <= 1'b0;
      age_cnt_q <= '0;
      age_tick  <= 1'b0;
    end else begin
      age_tick <= 1'b0;
      if (link_drop && gc0_q[GC0_LINK_AGE_BIT] && !fast_q) begin
        fast_q    <= 1'b1;
        age_cnt_q <= '0;
      end else if (fast_q ? (age_cnt_q >= 64'(FAST_CYC))
                          : (age_cnt_q >= 64'(AGE_CYC - 1))) begin
        age_tick  <= 1'b1;
        fast_q    <= 1'b0;
        age_cnt_q <= '0;
      end else begin
        age_cnt_q <= age_cnt_q + 64'h1;
      end
    end
  end
  assign fast_age_active = fast_q;
endmodule : sgc_global_ctrl
`default_nettype wire

// [testbench/sgc_monitor.sv]
// Port relation checker for the global control registers
`timescale 1ns/1ns
`default_nettype none
module sgc_monitor
  import sgc_pkg::*;
#(
  parameter int NPORT = 5
) (
  input wire logic                        clk,
  input wire logic                        arst_n,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [sgc_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [sgc_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic [sgc_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic [5:0]                  phy_mii_oe,
  input wire logic                        buf_share_all,
  input wire logic                        buf_per_port_fifth,
  input wire logic [NPORT-1:0]            auto_negotiation_tx_pause,
  input wire logic [NPORT-1:0]            tx_pause_en,
  input wire logic [NPORT-1:0]            port_link_up,
  input wire logic                        fast_age_active,
  input wire logic                        flush_all_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Output relations, link loss and read port behaviour
  property p_oe;
    reg_wr && reg_addr == ADDR_GLOBAL_CONTROL_ZERO && reg_wdata[GC0_MII_EN_BIT]
      |=> phy_mii_oe == 6'h3f;
  endproperty
  a_oe: assert property (p_oe) else $error("mii drivers off after enable");
  property p_oe_off;
    reg_wr && reg_addr == ADDR_GLOBAL_CONTROL_ZERO && !reg_wdata[GC0_MII_EN_BIT]
      |=> phy_mii_oe == 6'h00;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("mii drivers on after isolate");
  property p_share; buf_share_all != buf_per_port_fifth; endproperty
  a_share: assert property (p_share) else $error("share modes clash");
  property p_share_wr;
    reg_wr && reg_addr == ADDR_GLOBAL_CONTROL_ZERO && reg_wdata[GC0_SHARE_BIT]
      |=> buf_share_all;
  endproperty
  a_share_wr: assert property (p_share_wr) else $error("sharing not applied");
  property p_txfc; (tx_pause_en & ~auto_negotiation_tx_pause) == '0; endproperty
  a_txfc: assert property (p_txfc) else $error("tx pause without negotiation");
  property p_flush; |($past(port_link_up) & ~port_link_up) |=> flush_all_addr; endproperty
  a_flush: assert property (p_flush) else $error("no flush on unplug");
  property p_noflush;
    flush_all_addr |-> |($past(port_link_up, 2) & ~$past(port_link_up));
  endproperty
  a_noflush: assert property (p_noflush) else $error("flush without unplug");
  property p_fast; $rose(fast_age_active) |-> flush_all_addr; endproperty
  a_fast: assert property (p_fast) else $error("fast age without link loss");
  property p_unmap; reg_rd && reg_addr != ADDR_GLOBAL_CONTROL_ZERO
    && reg_addr != ADDR_GLOBAL_CONTROL_ONE |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : sgc_monitor
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the global control registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sgc_pkg::*;
  typedef struct packed {logic [6:0] a; logic [7:0] w; logic [7:0] r; logic [2:0] p; logic h;} sgc_row_t;
  localparam int     FC = 10;
  localparam longint AC = 100;
  logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, fv = 1'b1, fcf = 1'b0, fe = 1'b0;
  logic        smii = 1'b1, sfc = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [7:0]  wd = 8'h00, rdat;
  logic [2:0]  pri = 3'h0;
  logic [5:0]  mo, moe;
  logic [15:0] lt = 16'h0800, al = 16'h0000;
  logic [47:0] da = 48'h0;
  logic [4:0]  ant = 5'h00, anr = 5'h00, lnk = 5'h1f, txe, rxe;
  logic        hi, sha, fif, drp, tick, fast, flush;
  int          failures = 0, checked = 0, n;
  sgc_row_t    rows [5] = '{'{7'h02, 8'h30, 8'h30, 3'h3, 1'b1}, '{7'h02, 8'h3c, 8'h3c, 3'h2, 1'b0},
    '{7'h02, 8'hff, 8'hff, 3'h6, 1'b0}, '{7'h02, 8'h06, 8'h06, 3'h0, 1'b1},
    '{7'h7f, 8'haa, 8'h00, 3'h0, 1'b1}};
  logic [7:0]  fcv [4] = '{8'h20, 8'h10, 8'h30, 8'h00};
  sgc_global_ctrl #(.NPORT(5), .AGE_CYC(AC), .FAST_CYC(FC)) u_sgc_global_ctrl (
    .clk(clk), .arst_n(arst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdat), .phy_mii_enable_strap_pin(smii), .flow_control_strap_pin(sfc),
    .rx_user_priority(pri), .rx_high_priority(hi), .phy_mii_out(6'h2a), .phy_mii_o(mo),
    .phy_mii_oe(moe), .buf_share_all(sha), .buf_per_port_fifth(fif), .rx_frame_valid(fv),
    .rx_len_type(lt), .rx_dest_addr(da), .rx_is_flow_ctrl(fcf), .rx_frame_error(fe),
    .rx_actual_len(al), .rx_drop(drp), .auto_negotiation_tx_pause(ant),
    .auto_negotiation_rx_pause(anr), .tx_pause_en(txe), .rx_pause_en(rxe),
    .port_link_up(lnk), .age_tick(tick), .fast_age_active(fast), .flush_all_addr(flush));
  // Clock
  always #20 clk = ~clk;
  task automatic conclude;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    step();
    chk(rdat & m, e);
  endtask : rd_chk
  task automatic frm(input logic [15:0] t, input logic p, f, e, input logic [15:0] l, input logic x);
    @(posedge clk);
    lt <= t;
    da <= p ? PAUSE_DA : 48'h0;
    fcf <= f;
    fe <= e;
    al <= l;
    step();
    chk(drp, x);
  endtask : frm
  // Settled edges until the next age tick, bounded; a standing tick is skipped
  task automatic wait_tick;
    n = 0;
    do begin
      step();
      n++;
    end while (n < 300 && tick !== 1'b1);
    if (tick !== 1'b1) begin
      chk(tick, 1'b1);
      conclude();
    end
  endtask : wait_tick
  // Reset with given strap levels, then wait out the strap load
  task automatic do_reset(input logic m, input logic f);
    arst_n <= 1'b0;
    smii <= m;
    sfc <= f;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  initial begin
    do_reset(1'b1, 1'b0);
    rd_chk(ADDR_GLOBAL_CONTROL_ZERO, 8'hff, 8'h4c);
    rd_chk(ADDR_GLOBAL_CONTROL_ONE, 8'hff, 8'h00);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      pri <= rows[i].p;
      rd_chk(rows[i].a, 8'hff, rows[i].r);
      chk(hi, rows[i].h);
      chk(mo, 6'h2a);
      if (rows[i].a == ADDR_GLOBAL_CONTROL_ZERO) chk(moe, {6{rows[i].w[3]}});
      if (rows[i].a == ADDR_GLOBAL_CONTROL_ZERO) chk(sha, rows[i].w[2]);
      if (rows[i].a == ADDR_GLOBAL_CONTROL_ZERO) chk(fif, !rows[i].w[2]);
    end
    ant <= 5'h1b;
    anr <= 5'h1e;
    foreach (fcv[i]) begin
      wr_reg(ADDR_GLOBAL_CONTROL_ONE, fcv[i]);
      step();
      chk(txe, ant & ~{5{fcv[i][5]}});
      chk(rxe, anr & ~{5{fcv[i][4]}});
    end
    frm(16'h8808, 0, 0, 0, 16'h0, 1);
    frm(16'h0800, 1, 0, 0, 16'h0, 1);
    frm(16'h0800, 0, 0, 0, 16'h0, 0);
    frm(16'h0800, 0, 0, 1, 16'h0, 1);
    wr_reg(ADDR_GLOBAL_CONTROL_ZERO, 8'h04);
    frm(16'h8808, 0, 0, 0, 16'h0, 0);
    frm(16'h0800, 0, 1, 0, 16'h0, 1);
    wr_reg(ADDR_GLOBAL_CONTROL_ONE, 8'h80);
    frm(16'h0800, 0, 0, 1, 16'h0, 0);
    wr_reg(ADDR_GLOBAL_CONTROL_ONE, 8'h08);
    frm(16'h0040, 0, 0, 0, 16'h0050, 1);
    frm(16'h0040, 0, 0, 0, 16'h0040, 0);
    frm(16'h05dc, 0, 0, 0, 16'h0050, 0);
    wr_reg(ADDR_GLOBAL_CONTROL_ZERO, 8'h05);
    lnk <= 5'h1b;
    step();
    chk(flush, 1'b1);
    chk(fast, 1'b1);
    wait_tick();
    chk(n, FC + 1);
    wait_tick();
    chk(n, AC);
    chk(fast, 1'b0);
    wr_reg(ADDR_GLOBAL_CONTROL_ZERO, 8'h04);
    lnk <= 5'h17;
    step();
    chk(flush, 1'b1);
    chk(fast, 1'b0);
    // Mid-run reset with both straps flipped
    do_reset(1'b0, 1'b1);
    rd_chk(ADDR_GLOBAL_CONTROL_ZERO, 8'hff, 8'h44);
    rd_chk(ADDR_GLOBAL_CONTROL_ONE, 8'hff, 8'h30);
    chk(moe, 6'h00);
    chk(txe, 5'h00);
    chk(rxe, 5'h00);
    conclude();
  end
endmodule : tb_top
bind sgc_global_ctrl sgc_monitor #(.NPORT(NPORT)) u_sgc_monitor (
  .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .phy_mii_oe(phy_mii_oe),
  .buf_share_all(buf_share_all), .buf_per_port_fifth(buf_per_port_fifth),
  .auto_negotiation_tx_pause(auto_negotiation_tx_pause), .tx_pause_en(tx_pause_en),
  .port_link_up(port_link_up), .fast_age_active(fast_age_active),
  .flush_all_addr(flush_all_addr));
`default_nettype wire
